//--- hw/rcd_cfg.svh
/*
 Constants of the reset and initialisation sequencer: widths, timing and reset values.
 Assumes inclusion by bare name; holds definitions only.
*/
`ifndef RCD_CFG_SVH
`define RCD_CFG_SVH

`define CLK_FREQ_MHZ      100
`define STAB_TIME_US      15
`define STAB_CYCLES       (`STAB_TIME_US * `CLK_FREQ_MHZ)
`define STAB_CNT_W        11
`define CS_W              4
`define CKE_W             2
`define ODT_W             2
`define AC_W              22
`define CS_IDLE           4'hF
`define CKE_RESET         2'h0
`define ODT_RESET         2'h0
`define AC_RESET          22'h000000
`define MODE_RESET        1'h0
`define SYNC_RESET_LOW    1'h0

`endif

//--- hw/rcd_pkg.sv
/*
 Types of the reset and initialisation sequencer.
 Assumes rcd_cfg.svh sits in the include path.
*/
`include "rcd_cfg.svh"

package rcd_pkg;

   typedef struct packed
   {
      logic [`CS_W-1:0]  chip_select;
      logic [`CKE_W-1:0] clock_en;
      logic [`ODT_W-1:0] termination_control;
      logic [`AC_W-1:0]  addr_cmd;
   } ctl_in_t;

   typedef struct packed
   {
      logic              reset_n;
      logic              clock_stable;
      logic              four_select_n;
   } pin_in_t;

   typedef enum logic [1:0]
   {
      ST_RESET,
      ST_RELEASED,
      ST_STAB,
      ST_RUN
   } seq_state_t;

endpackage

//--- hw/rcd_sync.sv
/*
 Two-stage synchroniser for pin inputs, parameterised in width and reset value.
 Assumes a single clock domain on clk and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module rcd_sync
#(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         meta_ff <= INIT;
         sync_ff <= INIT;
      end
      else
      begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule

//--- hw/rcd_reset_init_sequencer.sv
/*
 Reset and initialisation sequencer of a registering clock driver: gates receivers,
 holds clock-enable outputs low and floats the rest in reset, times stabilisation.
 Assumes all pin inputs are asynchronous to clk and are synchronised here.
*/
// How it works
// - Reset low disables all input receivers; other inputs except the select-mode strap are ignored.
// - Reset low returns state, counter and outputs to default; the mode register captures the strap.
// - In reset, four clock-enable outputs drive low; all others float.
// - While reset is low, stay in low power with termination off.
// - Data path opens only after release and full stabilisation interval.
// - Leave reset only on rising reset edge with stable clock.
// - Reset is asynchronous to clock; entering it clears state promptly.
// - Chip-select group spans 1..0, or 3..0 in four-select mode.
// - After release, termination low until first edge, then follows input.
`timescale 1ns/1ps
`include "rcd_cfg.svh"

module rcd_reset_init_sequencer
   import rcd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              reset_pin_n,
   input  wire logic              clock_stable,
   input  wire logic              four_select_mode_n,
   input  wire logic [`CS_W-1:0]  chip_select_in,
   input  wire logic              clock_en_in0,
   input  wire logic              clock_en_in1,
   input  wire logic [`ODT_W-1:0] termination_control_in,
   input  wire logic [`AC_W-1:0]  addr_cmd_in,
   output logic                   side_a_clock_en_out0,
   output logic                   side_a_clock_en_out1,
   output logic                   side_b_clock_en_out0,
   output logic                   side_b_clock_en_out1,
   output logic      [`CS_W-1:0]  chip_select_out,
   output logic                   chip_select_oe_n,
   output logic      [`ODT_W-1:0] termination_control_out,
   output logic                   termination_control_oe_n,
   output logic      [`AC_W-1:0]  addr_cmd_out,
   output logic                   addr_cmd_oe_n,
   output logic                   input_term_en,
   output logic                   low_power,
   output logic                   four_select_mode,
   output logic                   data_path_ready
);

   pin_in_t    pin_raw;
   pin_in_t    pin_sync;
   ctl_in_t    ctl_raw;
   ctl_in_t    ctl_sync;
   ctl_in_t    ctl_rx;
   seq_state_t state_ff;
   seq_state_t nxt_state;
   logic                   rst_prev_ff;
   logic                   in_reset;
   logic                   release_edge;
   logic                   rx_en;
   logic [`STAB_CNT_W-1:0] stab_cnt_ff;
   logic [`STAB_CNT_W-1:0] nxt_stab_cnt;
   logic                   mode_ff;
   logic [`CS_W-1:0]       cs_masked;

   assign pin_raw = '{reset_n: reset_pin_n, clock_stable: clock_stable,
                      four_select_n: four_select_mode_n};
   assign ctl_raw = '{chip_select: chip_select_in,
                      clock_en: {clock_en_in1, clock_en_in0},
                      termination_control: termination_control_in,
                      addr_cmd: addr_cmd_in};

   // Pin levels pass two flip-flops before any logic reads them.
   rcd_sync
   #(
      .W    ($bits(pin_in_t)),
      .INIT ({`SYNC_RESET_LOW, 1'h0, 1'h1})
   )
   u_pin_sync
   (
      .clk  (clk),
      .nrst (nrst),
      .d    (pin_raw),
      .q    (pin_sync)
   );

   rcd_sync
   #(
      .W    ($bits(ctl_in_t)),
      .INIT ({`CS_IDLE, `CKE_RESET, `ODT_RESET, `AC_RESET})
   )
   u_ctl_sync
   (
      .clk  (clk),
      .nrst (nrst),
      .d    (ctl_raw),
      .q    (ctl_sync)
   );

   // Reset is caught on its own path, never clocked into the data path.
   assign in_reset     = !nrst || !pin_sync.reset_n;
   assign release_edge = pin_sync.reset_n && !rst_prev_ff;

   // Receivers pass data only once the sequence leaves reset.
   assign rx_en  = (state_ff != ST_RESET) && !in_reset;
   assign ctl_rx = rx_en ? ctl_sync : ctl_in_t'{chip_select: `CS_IDLE, clock_en: `CKE_RESET,
                                                termination_control: `ODT_RESET,
                                                addr_cmd: `AC_RESET};

   // Unused upper chip selects stay deselected in two-select mode.
   assign cs_masked = mode_ff ? ctl_rx.chip_select
                              : {2'h3, ctl_rx.chip_select[1:0]};

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         rst_prev_ff <= 1'h0;
      end
      else
      begin
         rst_prev_ff <= pin_sync.reset_n;
      end
   end

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_stab_cnt = stab_cnt_ff;
      case (state_ff)
         ST_RESET:
         begin
            nxt_stab_cnt = '0;
            if (release_edge && pin_sync.clock_stable)
            begin
               nxt_state = ST_RELEASED;
            end
         end
         ST_RELEASED:
         begin
            nxt_state = ST_STAB;
         end
         ST_STAB:
         begin
            if (stab_cnt_ff == `STAB_CNT_W'(`STAB_CYCLES - 1))
            begin
               nxt_state = ST_RUN;
            end
            else
            begin
               nxt_stab_cnt = stab_cnt_ff + `STAB_CNT_W'(1);
            end
         end
         ST_RUN:
         begin
            nxt_state = ST_RUN;
         end
         default:
         begin
            nxt_state = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (in_reset)
      begin
         state_ff    <= ST_RESET;
         stab_cnt_ff <= '0;
      end
      else
      begin
         state_ff    <= nxt_state;
         stab_cnt_ff <= nxt_stab_cnt;
      end
   end

   // The select-mode strap is caught while reset is held and kept afterwards.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         mode_ff <= `MODE_RESET;
      end
      else if (!pin_sync.reset_n)
      begin
         mode_ff <= !pin_sync.four_select_n;
      end
   end

   // Clock-enable outputs are always driven; low until the data path opens.
   always_ff @(posedge clk)
   begin
      if (in_reset || (state_ff != ST_RUN))
      begin
         side_a_clock_en_out0 <= 1'h0;
         side_a_clock_en_out1 <= 1'h0;
         side_b_clock_en_out0 <= 1'h0;
         side_b_clock_en_out1 <= 1'h0;
      end
      else
      begin
         side_a_clock_en_out0 <= ctl_rx.clock_en[0];
         side_a_clock_en_out1 <= ctl_rx.clock_en[1];
         side_b_clock_en_out0 <= ctl_rx.clock_en[0];
         side_b_clock_en_out1 <= ctl_rx.clock_en[1];
      end
   end

   // Chip selects float in reset, drive high while stabilising, then follow.
   always_ff @(posedge clk)
   begin
      if (in_reset)
      begin
         chip_select_out  <= `CS_IDLE;
         chip_select_oe_n <= 1'h1;
      end
      else if (state_ff == ST_RUN)
      begin
         chip_select_out  <= cs_masked;
         chip_select_oe_n <= 1'h0;
      end
      else
      begin
         chip_select_out  <= `CS_IDLE;
         chip_select_oe_n <= (nxt_state == ST_RESET);
      end
   end

   // Termination control is low right after release, then tracks its input.
   always_ff @(posedge clk)
   begin
      if (in_reset)
      begin
         termination_control_out  <= `ODT_RESET;
         termination_control_oe_n <= 1'h1;
      end
      else if (state_ff == ST_RESET)
      begin
         termination_control_out  <= `ODT_RESET;
         termination_control_oe_n <= (nxt_state == ST_RESET);
      end
      else if (state_ff == ST_RELEASED)
      begin
         termination_control_out  <= `ODT_RESET;
         termination_control_oe_n <= 1'h0;
      end
      else
      begin
         termination_control_out  <= ctl_rx.termination_control;
         termination_control_oe_n <= 1'h0;
      end
   end

   // Address and command outputs float in reset and carry data only in run.
   always_ff @(posedge clk)
   begin
      if (in_reset)
      begin
         addr_cmd_out  <= `AC_RESET;
         addr_cmd_oe_n <= 1'h1;
      end
      else if (state_ff == ST_RUN)
      begin
         addr_cmd_out  <= ctl_rx.addr_cmd;
         addr_cmd_oe_n <= 1'h0;
      end
      else
      begin
         addr_cmd_out  <= `AC_RESET;
         addr_cmd_oe_n <= (nxt_state == ST_RESET);
      end
   end

   // Power and termination status of the receivers.
   always_ff @(posedge clk)
   begin
      if (in_reset)
      begin
         low_power        <= 1'h1;
         input_term_en    <= 1'h0;
         four_select_mode <= `MODE_RESET;
         data_path_ready  <= 1'h0;
      end
      else
      begin
         low_power        <= (nxt_state == ST_RESET);
         input_term_en    <= (nxt_state != ST_RESET);
         four_select_mode <= mode_ff;
         data_path_ready  <= (nxt_state == ST_RUN);
      end
   end

endmodule

//--- testbench/rcd_seq_checker.sv
/*
 Assertions on the ports of the reset and initialisation sequencer.
 Assumes the single clock clk and the synchronous active-low reset nrst.
*/
`timescale 1ns/1ps
`include "rcd_cfg.svh"
module rcd_seq_checker
(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              reset_pin_n,
   input wire logic              clock_stable,
   input wire logic              side_a_clock_en_out0,
   input wire logic              side_a_clock_en_out1,
   input wire logic              side_b_clock_en_out0,
   input wire logic              side_b_clock_en_out1,
   input wire logic [`CS_W-1:0]  chip_select_out,
   input wire logic              chip_select_oe_n,
   input wire logic [`ODT_W-1:0] termination_control_out,
   input wire logic              termination_control_oe_n,
   input wire logic [`AC_W-1:0]  addr_cmd_out,
   input wire logic              addr_cmd_oe_n,
   input wire logic              input_term_en,
   input wire logic              low_power,
   input wire logic              four_select_mode,
   input wire logic              data_path_ready
);
   wire  [3:0]  cke;
   wire  [2:0]  oe_n;
   logic [11:0] stab_cnt_ff;
   logic [11:0] nxt_stab_cnt;
   assign cke = {side_a_clock_en_out0, side_a_clock_en_out1,
                 side_b_clock_en_out0, side_b_clock_en_out1};
   assign oe_n = {chip_select_oe_n, termination_control_oe_n, addr_cmd_oe_n};
   assign nxt_stab_cnt = low_power ? 12'h000 : stab_cnt_ff + 12'(stab_cnt_ff != 12'hFFF);
   always_ff @(posedge clk)
   begin
      if (!nrst)
         stab_cnt_ff <= 12'h000;
      else
         stab_cnt_ff <= nxt_stab_cnt;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   AST_CKE_LOW: assert property (low_power |-> cke == 4'h0)
      else $error("clock enable out high in reset");
   AST_FLOAT: assert property (low_power |-> oe_n == 3'h7 && !input_term_en)
      else $error("output driven in reset");
   AST_HOLD: assert property (low_power && $past(low_power) |->
      $stable({chip_select_out, termination_control_out, addr_cmd_out}))
      else $error("outputs moved in reset");
   AST_ENTRY: assert property ($fell(reset_pin_n) |-> ##[1:3] low_power)
      else $error("reset entry too slow");
   AST_REL_CLK: assert property ($fell(low_power) |-> $past(clock_stable, 2) && reset_pin_n)
      else $error("release without stable clock");
   AST_ODT_FIRST: assert property ($fell(low_power) |-> termination_control_out == 2'h0)
      else $error("termination not low at release");
   AST_STAB: assert property ($rose(data_path_ready) |->
      stab_cnt_ff >= `STAB_CYCLES - 1 && stab_cnt_ff <= `STAB_CYCLES + 3)
      else $error("stabilisation length wrong");
   AST_CS_TWO: assert property (!four_select_mode && !chip_select_oe_n |->
      chip_select_out[3:2] == 2'h3)
      else $error("upper selects active in two-select mode");
   COV_REL: cover property ($fell(low_power));
   COV_RUN: cover property ($rose(data_path_ready));
   COV_QUAD: cover property (four_select_mode && data_path_ready);
endmodule
bind rcd_reset_init_sequencer rcd_seq_checker chk
(
   .clk, .nrst, .reset_pin_n, .clock_stable, .side_a_clock_en_out0, .side_a_clock_en_out1,
   .side_b_clock_en_out0, .side_b_clock_en_out1, .chip_select_out, .chip_select_oe_n,
   .termination_control_out, .termination_control_oe_n, .addr_cmd_out, .addr_cmd_oe_n,
   .input_term_en, .low_power, .four_select_mode, .data_path_ready
);

//--- testbench/rcd_ctrl_model.sv
/*
 Controller model driving the reset, strap and command pins of the sequencer.
 Assumes its tasks are called just after a rising edge of clk.
*/
`timescale 1ns/1ps
`include "rcd_cfg.svh"
module rcd_ctrl_model
   import rcd_pkg::*;
#(
   parameter int PRE_CYC = 4
)
(
   input  wire logic clk,
   output pin_in_t   pin,
   output ctl_in_t   ctl
);
   initial
   begin
      pin = 3'h3;
      ctl = {`CS_IDLE, 2'h0, 2'h0, 22'h15A5A5};
   end
   // Inputs toggle once a cycle in reset to stand for floating receivers.
   task automatic hold_reset(input int n, input logic quad_n);
      pin.reset_n = 1'b0;
      pin.four_select_n = quad_n;
      repeat (n)
      begin
         ctl = ~ctl;
         @(posedge clk);
         #1;
      end
   endtask
   task automatic release_pin(input logic stable);
      ctl = {`CS_IDLE, 2'h0, 2'h3, 22'h000000};
      pin.clock_stable = stable;
      repeat (PRE_CYC) @(posedge clk);
      #1;
      pin.reset_n = 1'b1;
   endtask
   task automatic send(input logic [3:0] cs, input logic [1:0] cke, input logic [21:0] ac);
      ctl = {cs, cke, 2'h1, ac};
   endtask
endmodule

//--- testbench/rcd_reset_init_sequencer_tb.sv
/*
 Self-checking bench of the reset and initialisation sequencer.
 Assumes the controller model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "rcd_cfg.svh"
module rcd_reset_init_sequencer_tb
   import rcd_pkg::*;
;
   logic              clk;
   logic              nrst;
   pin_in_t           pin;
   ctl_in_t           ctl;
   logic              a0, a1, b0, b1, cs_oe_n, odt_oe_n, ac_oe_n, term_en, low_pwr, quad, ready;
   logic [`CS_W-1:0]  cs_out;
   logic [`ODT_W-1:0] odt_out;
   logic [`AC_W-1:0]  ac_out;
   int                err_total = 0;
   int                check_count = 0;
   rcd_ctrl_model ctrl (.clk(clk), .pin(pin), .ctl(ctl));
   rcd_reset_init_sequencer dut
   (
      .clk(clk), .nrst(nrst), .reset_pin_n(pin.reset_n), .clock_stable(pin.clock_stable),
      .four_select_mode_n(pin.four_select_n), .chip_select_in(ctl.chip_select),
      .clock_en_in0(ctl.clock_en[0]), .clock_en_in1(ctl.clock_en[1]),
      .termination_control_in(ctl.termination_control), .addr_cmd_in(ctl.addr_cmd),
      .side_a_clock_en_out0(a0), .side_a_clock_en_out1(a1), .side_b_clock_en_out0(b0),
      .side_b_clock_en_out1(b1), .chip_select_out(cs_out), .chip_select_oe_n(cs_oe_n),
      .termination_control_out(odt_out), .termination_control_oe_n(odt_oe_n),
      .addr_cmd_out(ac_out), .addr_cmd_oe_n(ac_oe_n), .input_term_en(term_en),
      .low_power(low_pwr), .four_select_mode(quad), .data_path_ready(ready)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_rst();
      chk("cke", {a0, a1, b0, b1}, 4'h0);
      chk("oe_n", {cs_oe_n, odt_oe_n, ac_oe_n}, 3'h7);
      chk("ac", ac_out, 22'h000000);
      chk("power", {low_pwr, term_en, ready}, 3'h4);
   endtask
   task automatic wait_ready(input int lo);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < lo + 20)
      begin
         tick(1);
         n++;
      end
      chk("stab", n >= lo && n <= lo + 12, 1'b1);
   endtask
   task automatic traffic(input logic [3:0] cs, input logic [3:0] cs_exp);
      ctrl.send(cs, 2'h2, 22'h2A5A5C);
      tick(4);
      chk("cke", {a0, a1, b0, b1}, 4'h5);
      chk("cs", cs_out, cs_exp);
      chk("oe_n_run", {cs_oe_n, odt_oe_n, ac_oe_n}, 3'h0);
      chk("odt_ac", {odt_out, ac_out}, {2'h1, 22'h2A5A5C});
   endtask
   task automatic t_power_up();
      ctrl.hold_reset(20000, 1'b1);
      chk_rst();
      ctrl.release_pin(1'b1);
      tick(3);
      chk("released", {low_pwr, term_en, cs_oe_n, odt_out}, 5'h08);
      tick(6);
      chk("stab", {ready, a0, a1, b0, b1, cs_out, odt_out}, 11'h03F);
      wait_ready(1490);
      traffic(4'hA, 4'hE);
   endtask
   task automatic t_entry();
      ctrl.hold_reset(3, 1'b0);
      chk_rst();
      ctrl.hold_reset(7, 1'b0);
   endtask
   task automatic t_four_mode();
      ctrl.release_pin(1'b1);
      wait_ready(1499);
      chk("mode", quad, 1'b1);
      traffic(4'h5, 4'h5);
   endtask
   task automatic t_refused();
      ctrl.hold_reset(10, 1'b1);
      ctrl.release_pin(1'b0);
      tick(20);
      chk("refused", low_pwr, 1'b1);
      ctrl.release_pin(1'b1);
      tick(10);
      chk("no_rise", low_pwr, 1'b1);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      nrst = 1'b0;
      tick(3);
      nrst = 1'b1;
      t_power_up();
      t_entry();
      t_four_mode();
      t_refused();
      finish_test();
   end
   initial
   begin
      #400000;
      err_total++;
      finish_test();
   end
endmodule
